//--- rtl/ptb_pkg.sv
// Package for the PWM time base and control block: offsets, fields, resets, types
package ptb_pkg;

  // Counter width and bus address width
  localparam int PTB_CNT_W = 12;
  localparam int PTB_ADR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_TIMER_CONTROL_LOW = 8'h00;
  localparam logic [7:0] OFF_TIMER_CONTROL_HIGH = 8'h04;
  localparam logic [7:0] OFF_TIME_BASE_COUNTER = 8'h08;
  localparam logic [7:0] OFF_PERIOD_VALUE = 8'h0C;
  localparam logic [7:0] OFF_PWM_OUTPUT_ENABLE_AND_PAIR_MODE = 8'h10;
  localparam logic [7:0] OFF_PWM_EVENT_TRIGGER_AND_UPDATE_CONTROL = 8'h14;
  localparam logic [7:0] OFF_EVENT_COMPARE = 8'h18;
  localparam logic [7:0] OFF_EVENT_STATUS = 8'h1C;
  localparam logic [7:0] OFF_ACTIVE_PERIOD = 8'h20;

  // Field positions
  localparam int POS_POSTSCALE = 4;
  localparam int POS_PRESCALE = 2;
  localparam int POS_MODE = 0;
  localparam int POS_ENABLE = 7;
  localparam int POS_DIRECTION = 6;
  localparam int POS_OUTPUT_ENABLE = 4;
  localparam int POS_PAIR_MODE = 0;
  localparam int POS_TRIG_POSTSCALE = 4;
  localparam int POS_TRIG_DIRECTION = 3;
  localparam int POS_UPDATE_DISABLE = 1;
  localparam int POS_OVERRIDE_SYNC = 0;
  localparam int POS_FLAG_TIME_BASE = 0;
  localparam int POS_FLAG_TRIGGER = 1;

  // Reset values
  localparam logic [7:0] RST_TIMER_CONTROL_LOW = 8'h00;
  localparam logic [2:0] RST_OUTPUT_ENABLE_CFG_CLEAR = 3'h7;
  localparam logic [2:0] RST_OUTPUT_ENABLE_CFG_SET = 3'h0;
  localparam logic [3:0] RST_PAIR_MODE = 4'h0;
  localparam logic [7:0] RST_CONTROL_1 = 8'h00;
  localparam logic [PTB_CNT_W-1:0] RST_COUNT = 12'h000;

  // Prescaler terminal counts for 1:1, 1:4, 1:16, 1:64
  localparam logic [5:0] PRE_LIM_1 = 6'h00;
  localparam logic [5:0] PRE_LIM_4 = 6'h03;
  localparam logic [5:0] PRE_LIM_16 = 6'h0F;
  localparam logic [5:0] PRE_LIM_64 = 6'h3F;

  // Cycles after reset release at which the configuration strap is applied
  localparam logic [1:0] STRAP_LOAD_CYCLE = 2'h2;

  // Time base modes, in field order
  typedef enum logic [1:0] {
    PTB_MODE_FREE,
    PTB_MODE_SINGLE,
    PTB_MODE_UPDOWN,
    PTB_MODE_UPDOWN_DOUBLE
  } ptb_mode_e;

  // Static configuration handed to the output stage
  typedef struct packed {
    logic [7:0] pin_enable;
    logic [3:0] pair_independent;
    logic override_sync;
  } ptb_cfg_s;

endpackage

//--- rtl/ptb_time_base.sv
// PWM time base, control registers and classic Wishbone register slave
// Function
// - Enable field selects which PWM pins drive
// - Enable field reset value comes from strap
// - Pair mode bit 1 independent, 0 complementary
// - Trigger postscale divides events by field plus one
// - Trigger allowed only in selected count direction
// - Update disable blocks buffer to active transfers
// - Override sync aligns overrides to time base
// - Free running counts up, wraps after period
// - Single shot wraps then hardware clears enable
// - Up/down turns downward after period match
// - Direction status bit read-only, 1 down
// - Outputs inactive first half after up/down start
// - Input clock prescaled 1, 4, 16, 64
// - Prescaler clears on counter or control write
// - Postscaler divides match events, clears likewise
// - Free running event on each period match
// - Single shot event ignores postscaler
// - Up/down event at zero turning upward
// - Counter twelve bits, runs only when enabled
// - Double update events at zero and period
`timescale 1ns/100ps
`default_nettype none

module ptb_time_base #(
  parameter int CNT_W = ptb_pkg::PTB_CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ptb_pkg::PTB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic output_enable_reset_config_i,
  input wire logic override_req_i,
  output ptb_pkg::ptb_cfg_s pwm_cfg_o,
  output logic [CNT_W-1:0] time_base_counter_o,
  output logic count_direction_status_o,
  output logic outputs_inactive_o,
  output logic buffer_transfer_o,
  output logic override_apply_o,
  output logic tb_event_o,
  output logic event_trigger_o
);
  import ptb_pkg::*;

  // Width limits that the logic can serve; reset constants are PTB_CNT_W wide
  if (CNT_W < 2 || CNT_W > PTB_CNT_W) begin : g_bad_width
    $error("CNT_W must lie between 2 and PTB_CNT_W");
  end

  // Pin enable decode of the output enable field
  function automatic logic [7:0] pin_decode(input logic [2:0] sel);
    case (sel)
      3'h1: pin_decode = 8'h02;
      3'h2: pin_decode = 8'h03;
      3'h3: pin_decode = 8'h0F;
      3'h4: pin_decode = 8'h3F;
      3'h5: pin_decode = 8'hFF;
      3'h6: pin_decode = 8'h0A;
      3'h7: pin_decode = 8'hAA;
      default: pin_decode = 8'h00;
    endcase
  endfunction

  // Prescaler terminal count for a select value
  function automatic logic [5:0] pre_limit(input logic [1:0] sel);
    case (sel)
      2'h0: pre_limit = PRE_LIM_1;
      2'h1: pre_limit = PRE_LIM_4;
      2'h2: pre_limit = PRE_LIM_16;
      default: pre_limit = PRE_LIM_64;
    endcase
  endfunction

  // Byte lane merge of a write into an old value
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wr,
                                              input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = sel[i] ? wr[i*8 +: 8] : old[i*8 +: 8];
    end
    lane_merge = old;
  endfunction

  // Register state
  logic [7:0] timer_control_low;
  logic time_base_enable;
  logic count_dir;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] period_buf;
  logic [CNT_W-1:0] period_act;
  logic [CNT_W-1:0] event_compare;
  logic [2:0] output_enable_select;
  logic [3:0] pair_mode_bits;
  logic [3:0] event_trigger_postscale;
  logic event_trigger_direction;
  logic buffer_update_disable;
  logic override_sync;
  logic [1:0] flags;
  logic ack;
  logic [5:0] pre_cnt;
  logic [3:0] post_cnt;
  logic [3:0] trig_cnt;
  logic first_half;
  logic ovr_pend;
  logic strap_meta;
  logic strap_sync;
  logic [1:0] strap_cnt;

  // Bus decode: a write takes effect at the edge where ack is seen high
  logic wr;
  logic [31:0] wmerge_cnt;
  logic [31:0] wmerge_per;
  logic [31:0] wmerge_cmp;
  logic wr_low;
  logic wr_high;
  logic wr_cnt;
  logic wr_con0;
  logic wr_con1;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack;
  assign wr_low = wr && wb_adr_i == OFF_TIMER_CONTROL_LOW && wb_sel_i[0];
  assign wr_high = wr && wb_adr_i == OFF_TIMER_CONTROL_HIGH && wb_sel_i[0];
  assign wr_cnt = wr && wb_adr_i == OFF_TIME_BASE_COUNTER && (wb_sel_i[1:0] != 2'h0);
  assign wr_con0 = wr && wb_adr_i == OFF_PWM_OUTPUT_ENABLE_AND_PAIR_MODE && wb_sel_i[0];
  assign wr_con1 = wr && wb_adr_i == OFF_PWM_EVENT_TRIGGER_AND_UPDATE_CONTROL && wb_sel_i[0];
  assign wmerge_cnt = lane_merge(32'(cnt), wb_dat_i, wb_sel_i);
  assign wmerge_per = lane_merge(32'(period_buf), wb_dat_i, wb_sel_i);
  assign wmerge_cmp = lane_merge(32'(event_compare), wb_dat_i, wb_sel_i);

  // Decoded control fields
  ptb_mode_e mode;
  logic updown;
  logic [3:0] postscale_sel;
  logic [1:0] prescale_sel;
  assign mode = ptb_mode_e'(timer_control_low[POS_MODE +: 2]);
  assign updown = (mode == PTB_MODE_UPDOWN) || (mode == PTB_MODE_UPDOWN_DOUBLE);
  assign postscale_sel = timer_control_low[POS_POSTSCALE +: 4];
  assign prescale_sel = timer_control_low[POS_PRESCALE +: 2];

  // Time base conditions seen on a prescaled tick
  logic pre_clr;
  logic tick;
  logic tick_en;
  logic at_per;
  logic at_zero;
  logic per_nz;
  logic edge_wrap;
  logic updn_top;
  logic updn_bot;
  logic raw_event;
  logic tb_fire;
  logic trig_match;
  logic trig_fire;
  logic boundary;
  assign pre_clr = wr_cnt || wr_low || wr_high;
  assign tick = pre_cnt == pre_limit(prescale_sel);
  assign tick_en = tick && time_base_enable;
  assign at_per = cnt == period_act;
  assign at_zero = cnt == '0;
  assign per_nz = period_act != '0;
  assign edge_wrap = tick_en && !updown && at_per;
  assign updn_top = tick_en && updown && !count_dir && at_per;
  assign updn_bot = tick_en && updown && count_dir && at_zero;
  assign boundary = edge_wrap || updn_bot;

  // Raw time base event per mode
  always_comb begin
    case (mode)
      PTB_MODE_FREE: raw_event = edge_wrap;
      PTB_MODE_SINGLE: raw_event = edge_wrap;
      PTB_MODE_UPDOWN: raw_event = updn_bot;
      PTB_MODE_UPDOWN_DOUBLE: raw_event = updn_bot || updn_top;
      default: raw_event = 1'b0;
    endcase
  end
  assign tb_fire = raw_event && (mode == PTB_MODE_SINGLE || post_cnt == postscale_sel);

  // Special event trigger: compare match in the chosen direction
  assign trig_match = tick_en && cnt == event_compare
                      && count_dir == event_trigger_direction;
  assign trig_fire = trig_match && trig_cnt == event_trigger_postscale;

  // Wishbone acknowledge, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= wb_cyc_i && wb_stb_i && !ack;
    end
  end

  // Read data captured with the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack) begin
      case (wb_adr_i)
        OFF_TIMER_CONTROL_LOW: wb_dat_o <= 32'(timer_control_low);
        OFF_TIMER_CONTROL_HIGH: wb_dat_o <= 32'({time_base_enable, count_dir, 6'h00});
        OFF_TIME_BASE_COUNTER: wb_dat_o <= 32'(cnt);
        OFF_PERIOD_VALUE: wb_dat_o <= 32'(period_buf);
        OFF_PWM_OUTPUT_ENABLE_AND_PAIR_MODE: wb_dat_o <= 32'({1'b0, output_enable_select,
                                                               pair_mode_bits});
        OFF_PWM_EVENT_TRIGGER_AND_UPDATE_CONTROL: wb_dat_o <= 32'({event_trigger_postscale,
          event_trigger_direction, 1'b0, buffer_update_disable, override_sync});
        OFF_EVENT_COMPARE: wb_dat_o <= 32'(event_compare);
        OFF_EVENT_STATUS: wb_dat_o <= 32'(flags);
        OFF_ACTIVE_PERIOD: wb_dat_o <= 32'(period_act);
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Timer control low: postscale, prescale and mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_control_low <= RST_TIMER_CONTROL_LOW;
    end else if (wr_low) begin
      timer_control_low <= wb_dat_i[7:0];
    end
  end

  // Enable: software sets or clears, single shot clears on its match
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      time_base_enable <= 1'b0;
    end else if (wr_high) begin
      time_base_enable <= wb_dat_i[POS_ENABLE];
    end else if (edge_wrap && mode == PTB_MODE_SINGLE) begin
      time_base_enable <= 1'b0;
    end
  end

  // Time base counter; kept when the enable is cleared
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= RST_COUNT[CNT_W-1:0];
    end else if (wr_cnt) begin
      cnt <= wmerge_cnt[CNT_W-1:0];
    end else if (tick_en) begin
      if (!updown) begin
        cnt <= at_per ? '0 : cnt + 1'b1;
      end else if (!count_dir) begin
        cnt <= at_per ? (per_nz ? cnt - 1'b1 : '0) : cnt + 1'b1;
      end else begin
        cnt <= at_zero ? (per_nz ? CNT_W'(1) : '0) : cnt - 1'b1;
      end
    end
  end

  // Count direction, only ever down in the up/down modes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_dir <= 1'b0;
    end else if (!updown) begin
      count_dir <= 1'b0;
    end else if (updn_top && per_nz) begin
      count_dir <= 1'b1;
    end else if (updn_bot && per_nz) begin
      count_dir <= 1'b0;
    end
  end

  // Period buffer and the active period it feeds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_buf <= RST_COUNT[CNT_W-1:0];
      period_act <= RST_COUNT[CNT_W-1:0];
    end else begin
      if (wr && wb_adr_i == OFF_PERIOD_VALUE) begin
        period_buf <= wmerge_per[CNT_W-1:0];
      end
      if (!buffer_update_disable && (boundary || !time_base_enable)) begin
        period_act <= period_buf;
      end
    end
  end

  // Duty buffer transfer strobe for the compare units
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buffer_transfer_o <= 1'b0;
    end else begin
      buffer_transfer_o <= boundary && !buffer_update_disable;
    end
  end

  // Prescaler counter
  always_ff @(posedge clk_i) begin
    if (rst_i || pre_clr) begin
      pre_cnt <= 6'h00;
    end else if (tick) begin
      pre_cnt <= 6'h00;
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  // Interrupt postscaler, bypassed in single shot
  always_ff @(posedge clk_i) begin
    if (rst_i || pre_clr) begin
      post_cnt <= 4'h0;
    end else if (raw_event && mode != PTB_MODE_SINGLE) begin
      post_cnt <= (post_cnt == postscale_sel) ? 4'h0 : post_cnt + 1'b1;
    end
  end

  // Event pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tb_event_o <= 1'b0;
      event_trigger_o <= 1'b0;
    end else begin
      tb_event_o <= tb_fire;
      event_trigger_o <= trig_fire;
    end
  end

  // Special event postscale counter
  always_ff @(posedge clk_i) begin
    if (rst_i || wr_con1) begin
      trig_cnt <= 4'h0;
    end else if (trig_match) begin
      trig_cnt <= trig_fire ? 4'h0 : trig_cnt + 1'b1;
    end
  end

  // Sticky event flags, write one to clear, set beats clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags <= 2'h0;
    end else begin
      flags <= (flags & ~((wr && wb_adr_i == OFF_EVENT_STATUS && wb_sel_i[0]) ?
                          wb_dat_i[1:0] : 2'h0))
               | {trig_fire, tb_fire};
    end
  end

  // Event compare value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_compare <= RST_COUNT[CNT_W-1:0];
    end else if (wr && wb_adr_i == OFF_EVENT_COMPARE) begin
      event_compare <= wmerge_cmp[CNT_W-1:0];
    end
  end

  // Outputs held inactive until the first turnaround of an up/down start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_half <= 1'b0;
    end else if (wr_high && wb_dat_i[POS_ENABLE] && !time_base_enable && updown) begin
      first_half <= 1'b1;
    end else if (updn_top || updn_bot || !time_base_enable) begin
      first_half <= 1'b0;
    end
  end

  // Configuration strap synchroniser and post reset load counter
  always_ff @(posedge clk_i) begin
    strap_meta <= output_enable_reset_config_i;
    strap_sync <= strap_meta;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_cnt <= 2'h0;
    end else if (strap_cnt != 2'h3) begin
      strap_cnt <= strap_cnt + 1'b1;
    end
  end

  // Output enable and pair mode register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_enable_select <= RST_OUTPUT_ENABLE_CFG_CLEAR;
      pair_mode_bits <= RST_PAIR_MODE;
    end else if (wr_con0) begin
      output_enable_select <= wb_dat_i[POS_OUTPUT_ENABLE +: 3];
      pair_mode_bits <= wb_dat_i[POS_PAIR_MODE +: 4];
    end else if (strap_cnt == STRAP_LOAD_CYCLE) begin
      output_enable_select <= strap_sync ? RST_OUTPUT_ENABLE_CFG_SET
                                         : RST_OUTPUT_ENABLE_CFG_CLEAR;
    end
  end

  // Event trigger and update control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {event_trigger_postscale, event_trigger_direction} <= RST_CONTROL_1[7:3];
      buffer_update_disable <= RST_CONTROL_1[POS_UPDATE_DISABLE];
      override_sync <= RST_CONTROL_1[POS_OVERRIDE_SYNC];
    end else if (wr_con1) begin
      event_trigger_postscale <= wb_dat_i[POS_TRIG_POSTSCALE +: 4];
      event_trigger_direction <= wb_dat_i[POS_TRIG_DIRECTION];
      buffer_update_disable <= wb_dat_i[POS_UPDATE_DISABLE];
      override_sync <= wb_dat_i[POS_OVERRIDE_SYNC];
    end
  end

  // Override apply: at once, or at the next period boundary when synced
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr_pend <= 1'b0;
      override_apply_o <= 1'b0;
    end else begin
      override_apply_o <= (ovr_pend || override_req_i) && (!override_sync || boundary);
      ovr_pend <= (ovr_pend || override_req_i) && override_sync && !boundary;
    end
  end

  // Output assignments
  assign wb_ack_o = ack;
  assign pwm_cfg_o.pin_enable = pin_decode(output_enable_select);
  assign pwm_cfg_o.pair_independent = pair_mode_bits;
  assign pwm_cfg_o.override_sync = override_sync;
  assign time_base_counter_o = cnt;
  assign count_direction_status_o = count_dir;
  assign outputs_inactive_o = first_half;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_pins_off;
    output_enable_select == 3'h0 |-> pwm_cfg_o.pin_enable == 8'h00;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("pins driven while disabled");

  property p_strap;
    strap_cnt == STRAP_LOAD_CYCLE && !wr_con0 |=>
      output_enable_select == ($past(strap_sync) ? 3'h0 : 3'h7);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not applied");

  property p_trig_dir;
    event_trigger_o |-> $past(count_dir) == $past(event_trigger_direction);
  endproperty
  a_trig_dir: assert property (p_trig_dir) else $error("trigger in wrong direction");

  property p_buffer_update_disable;
    buffer_update_disable |=> $stable(period_act) && !buffer_transfer_o;
  endproperty
  a_buffer_update_disable: assert property (p_buffer_update_disable) else $error("transfer while disabled");

  property p_free_wrap;
    tick_en && mode == PTB_MODE_FREE && at_per && !wr_cnt |=> cnt == '0 ##0 tb_event_o ==
      $past(post_cnt == postscale_sel);
  endproperty
  a_free_wrap: assert property (p_free_wrap) else $error("free running wrap wrong");

  property p_single_stop;
    tick_en && mode == PTB_MODE_SINGLE && at_per && !wr_cnt && !wr_high |=>
      !time_base_enable && cnt == '0 && tb_event_o;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single shot did not halt");

  property p_turn_down;
    updn_top && per_nz && !wr_cnt |=> count_dir && cnt == $past(period_act) - 1'b1;
  endproperty
  a_turn_down: assert property (p_turn_down) else $error("no turn at period");

  property p_pre_clear;
    pre_clr |=> pre_cnt == 6'h00 && post_cnt == 4'h0;
  endproperty
  a_pre_clear: assert property (p_pre_clear) else $error("scalers not cleared");

  property p_ctrl_keeps_cnt;
    (wr_low || wr_high) && !time_base_enable |=> $stable(cnt);
  endproperty
  a_ctrl_keeps_cnt: assert property (p_ctrl_keeps_cnt) else $error("control write hit counter");

  property p_flag;
    tb_fire |=> flags[POS_FLAG_TIME_BASE] && tb_event_o;
  endproperty
  a_flag: assert property (p_flag) else $error("event flag not set");

  property p_bot_event;
    mode == PTB_MODE_UPDOWN && updn_bot && post_cnt == postscale_sel |=> tb_event_o;
  endproperty
  a_bot_event: assert property (p_bot_event) else $error("missing zero event");

  c_single: cover property (edge_wrap && mode == PTB_MODE_SINGLE);
  c_turn: cover property (updn_top ##[1:200] updn_bot);
  c_trigger: cover property (event_trigger_o);

endmodule

`default_nettype wire

//--- bench/ptb_stage_model.sv
// Power stage model: the switch legs the PWM block lets conduct
`timescale 1ns/100ps
`default_nettype none
module ptb_stage_model
  import ptb_pkg::*;
(
  input wire ptb_pkg::ptb_cfg_s cfg_i,
  input wire logic inactive_i,
  output logic [7:0] legs_o
);
  // No leg conducts while the block holds its outputs inactive
  assign legs_o = inactive_i ? 8'h00 : cfg_i.pin_enable;
endmodule
`default_nettype wire

//--- bench/test_ptb_time_base.sv
// Self-checking bench for the PWM time base and control block
`timescale 1ns/100ps
`default_nettype none
module test_ptb_time_base;
  import ptb_pkg::*;
  localparam logic [7:0] A_TL = OFF_TIMER_CONTROL_LOW;
  localparam logic [7:0] A_TH = OFF_TIMER_CONTROL_HIGH;
  localparam logic [7:0] A_PM = OFF_PWM_OUTPUT_ENABLE_AND_PAIR_MODE;
  localparam logic [7:0] A_EV = OFF_PWM_EVENT_TRIGGER_AND_UPDATE_CONTROL;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic ovr = 1'b0;
  logic strap = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, dir, inact, btx, oapp, tbev, trev;
  logic [11:0] cnt;
  logic [7:0] legs;
  ptb_cfg_s cfg;
  int mismatches = 0;
  int n_compared = 0;
  int seed = 32'h2293_c717;
  logic [7:0] pins [8] = '{8'h00, 8'h02, 8'h03, 8'h0F, 8'h3F, 8'hFF, 8'h0A, 8'hAA};

  ptb_time_base dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
    .output_enable_reset_config_i(strap), .override_req_i(ovr), .pwm_cfg_o(cfg),
    .time_base_counter_o(cnt), .count_direction_status_o(dir), .outputs_inactive_o(inact),
    .buffer_transfer_o(btx), .override_apply_o(oapp), .tb_event_o(tbev), .event_trigger_o(trev));
  ptb_stage_model stage (.cfg_i(cfg), .inactive_i(inact), .legs_o(legs));

  // Clock at 200 MHz
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // Verdict and end of run
  task automatic report_and_stop;
    $display("Compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Compare one value
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Classic single cycle, held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0;
    if (k >= 50) begin
      chk("ack", 1, 0);
      report_and_stop();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    wb(1'b0, a, 32'h0000_0000);
    chk(n, e, q);
  endtask

  // Cycles up to the next pulse, bounded
  task automatic await(input bit t, output int g);
    g = 0;
    do begin
      @(negedge clk_i);
      g++;
    end while ((t ? trev : tbev) !== 1'b1 && g < 20000);
    if (g >= 20000) begin
      chk("pulse", 1, 0);
      report_and_stop();
    end
  endtask

  task automatic gap(input bit t, input int e, input string n);
    int g;
    await(t, g);
    await(t, g);
    chk(n, e, g);
  endtask

  // Expected cycles between events for a mode, period and scalers
  function automatic int ticks(input int m, input int p, input int ps, input int post);
    int per;
    per = (m == 0) ? p + 1 : (m == 3) ? p : 2 * p;
    return per * (1 << (2 * ps)) * (post + 1);
  endfunction

  // Stop, clear counter, load period and mode, then start
  task automatic setup(input int m, input int p, input int ps, input int post);
    wb(1'b1, A_TH, 32'h0000_0000);
    wb(1'b1, OFF_TIME_BASE_COUNTER, 32'h0000_0000);
    wb(1'b1, OFF_PERIOD_VALUE, 32'(p));
    wb(1'b1, A_TL, 32'((post << 4) | (ps << 2) | m));
    wb(1'b1, A_TH, 32'h0000_0080);
  endtask

  // Main sequence
  initial begin
    int p, ps, post, g, n;
    logic [3:0] pm;
    logic [31:0] c1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(A_PM, 32'h0000_0000, "pm_reset");
    rd(A_EV, 32'h0000_0000, "ev_reset");
    rd(8'h3C, 32'h0000_0000, "unmapped");
    // Every enable code, random pair modes, reserved bit set
    for (int c = 0; c < 8; c++) begin
      pm = 4'($random(seed));
      wb(1'b1, A_PM, 32'({1'b1, c[2:0], pm}));
      @(negedge clk_i);
      chk("pin_enable", pins[c], cfg.pin_enable);
      chk("pair_mode", pm, cfg.pair_independent);
      rd(A_PM, 32'({c[2:0], pm}), "pm_back");
    end
    wb(1'b1, A_PM, 32'h0000_0055);
    // Free running under every prescale, random period and postscale
    for (ps = 0; ps < 4; ps++) begin
      p = 1 + ($unsigned($random(seed)) % 7);
      post = $unsigned($random(seed)) % 16;
      setup(0, p, ps, post);
      gap(1'b0, ticks(0, p, ps, post), "free_gap");
    end
    // Up/down start, outputs held until turnaround
    p = 2 + ($unsigned($random(seed)) % 8);
    post = $unsigned($random(seed)) % 4;
    setup(2, p, 0, post);
    @(negedge clk_i);
    chk("inactive", 1, inact);
    chk("legs", 0, legs);
    gap(1'b0, ticks(2, p, 0, post), "ud_gap");
    chk("inactive", 0, inact);
    setup(3, p, 1, 0);
    gap(1'b0, ticks(3, p, 1, 0), "double_gap");
    // Single shot ignores postscale and stops itself
    setup(1, 5, 0, 7);
    await(1'b0, g);
    rd(A_TH, 32'h0000_0000, "ss_enable");
    rd(OFF_TIME_BASE_COUNTER, 32'h0000_0000, "ss_count");
    wb(1'b0, OFF_EVENT_STATUS, 32'h0000_0000);
    chk("flag_set", 1, q[0]);
    wb(1'b1, OFF_EVENT_STATUS, 32'h0000_0001);
    wb(1'b0, OFF_EVENT_STATUS, 32'h0000_0000);
    chk("flag_clr", 0, q[0]);
    // Stopping keeps the count; control writes do not clear it
    setup(0, 300, 0, 0);
    repeat (50) @(negedge clk_i);
    wb(1'b1, A_TH, 32'h0000_0040);
    @(negedge clk_i);
    c1 = 32'(cnt);
    chk("count_run", 1, c1 != 0);
    wb(1'b1, A_TL, 32'h0000_0000);
    rd(OFF_TIME_BASE_COUNTER, c1, "count_kept");
    rd(A_TH, 32'h0000_0000, "dir_ro");
    wb(1'b1, OFF_TIME_BASE_COUNTER, 32'hFFFF_FFFF);
    rd(OFF_TIME_BASE_COUNTER, 32'h0000_0FFF, "count_w");
    // Special event in each direction, top postscale as corner
    for (int d = 0; d < 2; d++) begin
      post = d ? 15 : $unsigned($random(seed)) % 4;
      wb(1'b1, OFF_EVENT_COMPARE, 32'h0000_0004);
      wb(1'b1, A_EV, 32'((post << 4) | (d << 3)));
      setup(2, 8, 0, 0);
      gap(1'b1, ticks(2, 8, 0, post), "trig_gap");
      chk("trig_dir", d, dir);
    end
    // Buffer transfers blocked, then allowed
    setup(0, 3, 0, 0);
    for (int u = 0; u < 2; u++) begin
      wb(1'b1, A_EV, 32'(2 - 2 * u));
      n = 0;
      repeat (40) begin
        @(negedge clk_i);
        n += (btx === 1'b1);
      end
      chk("transfers", u, n > 0);
    end
    // Override applied at once, or held for the time base
    setup(0, 200, 0, 0);
    for (int s = 0; s < 2; s++) begin
      wb(1'b1, A_EV, 32'(s));
      @(posedge clk_i);
      ovr <= 1'b1;
      @(posedge clk_i);
      ovr <= 1'b0;
      @(negedge clk_i);
      chk("override", 1 - s, oapp);
      chk("override_sync", s, cfg.override_sync);
      n = 0;
      repeat (210) begin
        @(negedge clk_i);
        n += (oapp === 1'b1);
      end
      chk("override_late", s, n);
    end
    // Mid-run reset with the strap low selects the other field value
    @(posedge clk_i);
    strap <= 1'b0;
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(A_PM, 32'h0000_0070, "pm_strap0");
    chk("pin_strap0", 8'hAA, cfg.pin_enable);
    rd(OFF_TIME_BASE_COUNTER, 32'h0000_0000, "count_reset");
    report_and_stop();
  end
endmodule
`default_nettype wire
